// >>> tiv_defs.vh
// Constants for the triple interval timer: offsets, fields, resets, timing.
// Included by the timer design files; holds definitions only.
`ifndef TIV_DEFS_VH
`define TIV_DEFS_VH

// Block placement in local I/O space, and register byte offsets
`define TIV_TIMER_BLOCK_BASE 16'h4000
`define TIV_OFF_COUNTER_ZERO_DATA 5'h00
`define TIV_OFF_COUNTER_ONE_DATA 5'h04
`define TIV_OFF_COUNTER_TWO_DATA 5'h08
`define TIV_OFF_COUNTER_CONTROL_BYTE 5'h0C
`define TIV_OFF_IRQ_STS_KEEP 5'h10
`define TIV_OFF_IRQ_STS_CLEAR 5'h14

// Control byte fields
`define TIV_CB_SEL 7:6
`define TIV_CB_RW 5:4
`define TIV_CB_MODE 3:1
`define TIV_CB_BCD 0
`define TIV_SEL_READBACK 2'h3
`define TIV_RB_NO_COUNT 5
`define TIV_RB_NO_STATUS 4

// Byte access formats
`define TIV_RW_LATCH 2'h0
`define TIV_RW_LSB 2'h1
`define TIV_RW_MSB 2'h2
`define TIV_RW_BOTH 2'h3

// Counting modes as kept by the engine
`define TIV_MODE_ONESHOT 3'h0
`define TIV_MODE_HW_ONESHOT 3'h1
`define TIV_MODE_SQUARE 3'h3
`define TIV_MODE_HW_STROBE 3'h5

// Interrupt status register fields
`define TIV_ST_EXP 1:0
`define TIV_ST_EN 5:4

// Reset values
`define TIV_RST_EN 2'h0
`define TIV_RST_EXP 2'h0
`define TIV_RST_MODE 3'h0
`define TIV_RST_RW 2'h3
`define TIV_RST_COUNT 16'h0000

// Timing: system clock and the fixed counter clock
`define TIV_SYS_CLK_HZ 100000000
`define TIV_FIXED_CLK_HZ 10000000
`define TIV_FIXED_DIV (`TIV_SYS_CLK_HZ / `TIV_FIXED_CLK_HZ)

`endif

// >>> tiv_sync.v
// Two-flop synchronisers with falling-edge detect for the connector inputs.
// Assumes asynchronous pin levels; edges compare the second stage with a third flop.
`timescale 1ns/1ns
`default_nettype none

module tiv_sync (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Raw levels
   input wire [2:0] d,
   // Synchronised levels and high-to-low pulses
   output wire [2:0] q,
   output wire [2:0] fall
);
   reg [2:0] meta_r;
   reg [2:0] sync_r;
   reg [2:0] prev_r;

   always @(posedge clk) begin
      if (!resetn) begin
         meta_r <= 3'h7;
         sync_r <= 3'h7;
         prev_r <= 3'h7;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign q = sync_r;
   assign fall = prev_r & ~sync_r;
endmodule

`default_nettype wire

// >>> tiv_timer.v
// Triple interval timer: three 16-bit down counters behind a bytewide port.
// Assumes one-cycle IO_RD/IO_WR strobes synchronous to CLK_SYS.
`timescale 1ns/1ns
`default_nettype none
`include "tiv_defs.vh"

module tiv_timer (
   // System
   input wire CLK_SYS,
   input wire RESETN,
   // Local I/O register port
   input wire [15:0] IO_ADDR,
   input wire IO_RD,
   input wire IO_WR,
   input wire [7:0] IO_WDATA,
   output reg [7:0] IO_RDATA,
   output reg IO_ACK,
   // Board control bit enabling modes 1 and 5 on counter zero only
   input wire MODES15_EN,
   // Connector pins, active low
   input wire TMR_MINOR_IP_N,
   input wire TMR_MAJOR_IP_N,
   output wire TMR1_EXT_OP_N,
   output wire TMR2_EXT_OP_N,
   // Interrupt requests
   output wire TMR_IRQ,
   output wire LOCAL_IRQ3
);
   localparam integer FIX_DIV_INT = `TIV_FIXED_DIV - 1;
   localparam [3:0] FIX_DIV_LAST = FIX_DIV_INT[3:0];
   localparam [15:0] BLOCK_BASE = `TIV_TIMER_BLOCK_BASE;

   function [15:0] dec1;
      input [15:0] v;
      input bcd;
      reg [15:0] r;
      reg borrow;
      integer k;
      begin
         r = v;
         borrow = 1'b1;
         if (!bcd) begin
            r = v - 16'h0001;
         end else begin
            for (k = 0; k < 4; k = k + 1) begin
               if (borrow) begin
                  if (r[4*k +: 4] == 4'h0) begin
                     r[4*k +: 4] = 4'h9;
                  end else begin
                     r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                     borrow = 1'b0;
                  end
               end
            end
         end
         dec1 = r;
      end
   endfunction

   function [7:0] pick_byte;
      input [15:0] v;
      input [1:0] rw;
      input hi;
      begin
         if (rw == `TIV_RW_MSB || (rw == `TIV_RW_BOTH && hi))
            pick_byte = v[15:8];
         else
            pick_byte = v[7:0];
      end
   endfunction

   function [2:0] eff_mode;
      input [2:0] m;
      input ok15;
      begin
         case (m)
            3'h1: eff_mode = ok15 ? `TIV_MODE_HW_ONESHOT : `TIV_MODE_ONESHOT;
            3'h5: eff_mode = ok15 ? `TIV_MODE_HW_STROBE : `TIV_MODE_ONESHOT;
            3'h0, 3'h4: eff_mode = `TIV_MODE_ONESHOT;
            default: eff_mode = `TIV_MODE_SQUARE;
         endcase
      end
   endfunction

   // Pin conditioning: bit 0 counter zero clock, 1 its gate, 2 mode strap
   wire [2:0] pin_q;
   wire [2:0] pin_fall;

   tiv_sync u_sync (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .d({MODES15_EN, TMR_MAJOR_IP_N, TMR_MINOR_IP_N}),
      .q(pin_q),
      .fall(pin_fall)
   );

   // Fixed 10 MHz count ticks for counters one and two
   reg [3:0] fix_div_r;
   wire fix_tick = (fix_div_r == FIX_DIV_LAST);

   always @(posedge CLK_SYS) begin
      if (!RESETN)
         fix_div_r <= 4'h0;
      else if (fix_tick)
         fix_div_r <= 4'h0;
      else
         fix_div_r <= fix_div_r + 4'h1;
   end

   wire [2:0] tick = {fix_tick, fix_tick, pin_fall[0]};
   wire [2:0] trig = {2'b00, pin_fall[1]};
   wire [2:0] ok15 = {2'b00, pin_q[2]};

   // Register decode
   wire blk_hit = (IO_ADDR[15:5] == BLOCK_BASE[15:5]);
   wire [4:0] off = IO_ADDR[4:0];
   reg [2:0] cnt_wr;
   reg [2:0] cnt_rd;
   reg ctl_wr;
   reg sts_wr;
   reg sts_rd;
   reg sts_clr;

   always @* begin
      cnt_wr = 3'h0;
      cnt_rd = 3'h0;
      ctl_wr = 1'b0;
      sts_wr = 1'b0;
      sts_rd = 1'b0;
      sts_clr = 1'b0;
      if (blk_hit && (IO_RD || IO_WR)) begin
         if (off == `TIV_OFF_COUNTER_ZERO_DATA) begin
            cnt_wr[0] = IO_WR;
            cnt_rd[0] = IO_RD;
         end else if (off == `TIV_OFF_COUNTER_ONE_DATA) begin
            cnt_wr[1] = IO_WR;
            cnt_rd[1] = IO_RD;
         end else if (off == `TIV_OFF_COUNTER_TWO_DATA) begin
            cnt_wr[2] = IO_WR;
            cnt_rd[2] = IO_RD;
         end else if (off == `TIV_OFF_COUNTER_CONTROL_BYTE) begin
            ctl_wr = IO_WR;
         end else if (off == `TIV_OFF_IRQ_STS_KEEP) begin
            sts_wr = IO_WR;
            sts_rd = IO_RD;
         end else if (off == `TIV_OFF_IRQ_STS_CLEAR) begin
            sts_wr = IO_WR;
            sts_rd = IO_RD;
            sts_clr = IO_RD;
         end
      end
   end

   // Control byte steering and readback command
   reg [2:0] ctl_we;
   reg [2:0] latch_cnt;
   reg [2:0] latch_sts;
   integer ci;

   always @* begin
      ctl_we = 3'h0;
      latch_cnt = 3'h0;
      latch_sts = 3'h0;
      if (ctl_wr) begin
         if (IO_WDATA[`TIV_CB_SEL] == `TIV_SEL_READBACK) begin
            for (ci = 0; ci < 3; ci = ci + 1) begin
               latch_cnt[ci] = IO_WDATA[ci + 1] & ~IO_WDATA[`TIV_RB_NO_COUNT];
               latch_sts[ci] = IO_WDATA[ci + 1] & ~IO_WDATA[`TIV_RB_NO_STATUS];
            end
         end else begin
            ctl_we[IO_WDATA[`TIV_CB_SEL]] = 1'b1;
         end
      end
   end

   // Counter engines
   wire [2:0] cnt_out;
   wire [23:0] rd_bytes;
   genvar gi;

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
         reg [2:0] mode_r;
         reg bcd_r;
         reg [1:0] rw_r;
         reg [15:0] cr_r;
         reg [15:0] ce_r;
         reg [15:0] ol_r;
         reg [7:0] st_r;
         reg out_r;
         reg pend_r;
         reg run_r;
         reg armed_r;
         reg have_r;
         reg wlo_r;
         reg rhi_r;
         reg olat_r;
         reg stlat_r;
         reg null_r;
         wire [15:0] ce_dec = dec1(ce_r, bcd_r);
         wire [15:0] ce_dec2 = dec1(ce_dec, bcd_r);
         wire [15:0] cr_even = {cr_r[15:1], 1'b0};
         wire sq_term = (out_r && cr_r[0]) ? (ce_r == 16'h0000) : (ce_r == 16'h0002);
         wire [2:0] new_mode = eff_mode(IO_WDATA[`TIV_CB_MODE], ok15[gi]);
         wire byte_done = cnt_wr[gi] && (rw_r != `TIV_RW_BOTH || wlo_r);

         always @(posedge CLK_SYS) begin
            if (!RESETN) begin
               mode_r <= `TIV_RST_MODE;
               bcd_r <= 1'b0;
               rw_r <= `TIV_RST_RW;
               cr_r <= `TIV_RST_COUNT;
               ce_r <= `TIV_RST_COUNT;
               ol_r <= `TIV_RST_COUNT;
               st_r <= 8'h00;
               out_r <= 1'b1;
               pend_r <= 1'b0;
               run_r <= 1'b0;
               armed_r <= 1'b0;
               have_r <= 1'b0;
               wlo_r <= 1'b0;
               rhi_r <= 1'b0;
               olat_r <= 1'b0;
               stlat_r <= 1'b0;
               null_r <= 1'b1;
            end else begin
               if (trig[gi])
                  armed_r <= 1'b1;
               // Count engine, advanced on this counter's tick
               if (tick[gi]) begin
                  case (mode_r)
                     `TIV_MODE_ONESHOT: begin
                        if (pend_r) begin
                           ce_r <= cr_r;
                           pend_r <= 1'b0;
                           run_r <= 1'b1;
                           null_r <= 1'b0;
                        end else if (run_r) begin
                           ce_r <= ce_dec;
                           if (ce_dec == 16'h0000)
                              out_r <= 1'b1;
                        end
                     end
                     `TIV_MODE_HW_ONESHOT: begin
                        if (armed_r && have_r) begin
                           ce_r <= cr_r;
                           out_r <= 1'b0;
                           armed_r <= trig[gi];
                           run_r <= 1'b1;
                           null_r <= 1'b0;
                        end else if (run_r) begin
                           ce_r <= ce_dec;
                           if (ce_dec == 16'h0000) begin
                              out_r <= 1'b1;
                              run_r <= 1'b0;
                           end
                        end
                     end
                     `TIV_MODE_HW_STROBE: begin
                        if (armed_r && have_r) begin
                           ce_r <= cr_r;
                           out_r <= 1'b1;
                           armed_r <= trig[gi];
                           run_r <= 1'b1;
                           null_r <= 1'b0;
                        end else if (!out_r) begin
                           out_r <= 1'b1;
                        end else if (run_r) begin
                           ce_r <= ce_dec;
                           if (ce_dec == 16'h0000) begin
                              out_r <= 1'b0;
                              run_r <= 1'b0;
                           end
                        end
                     end
                     default: begin
                        // Gate fall on counter zero restarts the wave at its next tick
                        if ((pend_r && !run_r) || (armed_r && have_r)) begin
                           ce_r <= cr_even;
                           out_r <= 1'b1;
                           pend_r <= 1'b0;
                           armed_r <= trig[gi];
                           run_r <= 1'b1;
                           null_r <= 1'b0;
                        end else if (run_r) begin
                           if (sq_term) begin
                              out_r <= ~out_r;
                              ce_r <= cr_even;
                              pend_r <= 1'b0;
                              null_r <= 1'b0;
                           end else begin
                              ce_r <= ce_dec2;
                           end
                        end
                     end
                  endcase
               end
               // Latches for readback
               if (latch_cnt[gi] && !olat_r) begin
                  ol_r <= ce_r;
                  olat_r <= 1'b1;
               end
               if (latch_sts[gi] && !stlat_r) begin
                  st_r <= {out_r, null_r, rw_r, mode_r, bcd_r};
                  stlat_r <= 1'b1;
               end
               // Data reads: status first, then latched or live count
               if (cnt_rd[gi]) begin
                  if (stlat_r) begin
                     stlat_r <= 1'b0;
                  end else begin
                     if (rw_r == `TIV_RW_BOTH)
                        rhi_r <= ~rhi_r;
                     if (olat_r && (rw_r != `TIV_RW_BOTH || rhi_r))
                        olat_r <= 1'b0;
                  end
               end
               // Data writes
               if (cnt_wr[gi]) begin
                  case (rw_r)
                     `TIV_RW_LSB: cr_r <= {8'h00, IO_WDATA};
                     `TIV_RW_MSB: cr_r <= {IO_WDATA, 8'h00};
                     default: begin
                        if (wlo_r)
                           cr_r[15:8] <= IO_WDATA;
                        else
                           cr_r[7:0] <= IO_WDATA;
                        wlo_r <= ~wlo_r;
                     end
                  endcase
               end
               if (byte_done) begin
                  pend_r <= 1'b1;
                  have_r <= 1'b1;
                  null_r <= 1'b1;
                  if (mode_r == `TIV_MODE_ONESHOT)
                     out_r <= 1'b0;
               end
               // Control byte for this counter
               if (ctl_we[gi]) begin
                  if (IO_WDATA[`TIV_CB_RW] == `TIV_RW_LATCH) begin
                     if (!olat_r) begin
                        ol_r <= ce_r;
                        olat_r <= 1'b1;
                     end
                  end else begin
                     mode_r <= new_mode;
                     bcd_r <= IO_WDATA[`TIV_CB_BCD];
                     rw_r <= IO_WDATA[`TIV_CB_RW];
                     out_r <= (new_mode != `TIV_MODE_ONESHOT);
                     wlo_r <= 1'b0;
                     rhi_r <= 1'b0;
                     olat_r <= 1'b0;
                     pend_r <= 1'b0;
                     run_r <= 1'b0;
                     armed_r <= 1'b0;
                     have_r <= 1'b0;
                     null_r <= 1'b1;
                  end
               end
            end
         end

         assign cnt_out[gi] = out_r;
         assign rd_bytes[gi*8 +: 8] = stlat_r ? st_r : pick_byte(olat_r ? ol_r : ce_r, rw_r, rhi_r);
      end
   endgenerate

   // Expiration status and interrupt enables
   reg [1:0] exp_r;
   reg [1:0] en_r;
   reg [2:0] out_d_r;
   wire [1:0] rise = {cnt_out[2] & ~out_d_r[2], cnt_out[0] & ~out_d_r[0]};

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         exp_r <= `TIV_RST_EXP;
         en_r <= `TIV_RST_EN;
         out_d_r <= 3'h7;
      end else begin
         out_d_r <= cnt_out;
         exp_r <= (sts_clr ? 2'h0 : exp_r) | rise;
         if (sts_wr)
            en_r <= IO_WDATA[`TIV_ST_EN];
      end
   end

   assign TMR_IRQ = |(exp_r & en_r);
   assign LOCAL_IRQ3 = cnt_out[1];
   assign TMR1_EXT_OP_N = ~cnt_out[1];
   assign TMR2_EXT_OP_N = ~cnt_out[2];

   // Bus answer, one cycle after the strobe
   reg [7:0] rd_mux;

   always @* begin
      rd_mux = 8'h00;
      if (cnt_rd[0])
         rd_mux = rd_bytes[7:0];
      else if (cnt_rd[1])
         rd_mux = rd_bytes[15:8];
      else if (cnt_rd[2])
         rd_mux = rd_bytes[23:16];
      else if (sts_rd)
         rd_mux = {2'b00, en_r, 2'b00, exp_r};
   end

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         IO_RDATA <= 8'h00;
         IO_ACK <= 1'b0;
      end else begin
         IO_ACK <= blk_hit && (IO_RD || IO_WR);
         if (IO_RD && blk_hit)
            IO_RDATA <= rd_mux;
      end
   end
endmodule

`default_nettype wire

// >>> tiv_timer_properties.sv
// Concurrent checks on the timer register port and interrupt pins.
// Bound to tiv_timer; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "tiv_defs.vh"

module tiv_timer_props (
   // System
   input wire logic CLK_SYS,
   input wire logic RESETN,
   // Register port
   input wire logic [15:0] IO_ADDR,
   input wire logic IO_RD,
   input wire logic IO_WR,
   input wire logic [7:0] IO_RDATA,
   input wire logic IO_ACK,
   // Pins and interrupts
   input wire logic TMR1_EXT_OP_N,
   input wire logic TMR2_EXT_OP_N,
   input wire logic TMR_IRQ,
   input wire logic LOCAL_IRQ3
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);
   wire hit = IO_ADDR[15:5] == 11'h200;
   wire stb = IO_RD || IO_WR;

   a_ack_hit: assert property (stb && hit |=> IO_ACK)
      else $error("no ack after hit");
   a_ack_miss: assert property (stb && !hit |=> !IO_ACK)
      else $error("ack outside block");
   a_ack_cause: assert property (IO_ACK |-> $past(stb && hit))
      else $error("ack without strobe");
   a_ack_single: assert property (stb && hit ##1 !stb |=> !IO_ACK)
      else $error("ack too long");
   a_rdata_hold: assert property (!$past(IO_RD && hit) |-> $stable(IO_RDATA))
      else $error("read data moved");
   a_ctl_rd_zero: assert property (IO_RD && hit
      && IO_ADDR[4:0] == `TIV_OFF_COUNTER_CONTROL_BYTE |=> IO_RDATA == 8'h00)
      else $error("control read not zero");
   a_gap_rd_zero: assert property (IO_RD && hit && IO_ADDR[4:3] == 2'h3
      |=> IO_RDATA == 8'h00)
      else $error("unused slot read not zero");
   a_irq_fall_src: assert property ($fell(TMR_IRQ) |-> $past(hit && (IO_WR
      && IO_ADDR[4:3] == 2'h2 || IO_RD && IO_ADDR[4:2] == 3'h5)))
      else $error("irq dropped without cause");
   a_irq3_pin: assert property (LOCAL_IRQ3 == !TMR1_EXT_OP_N)
      else $error("irq3 and pin disagree");

   c_irq_up: cover property ($rose(TMR_IRQ));
   c_irq_down: cover property ($fell(TMR_IRQ));
   c_ctr2_rise: cover property ($fell(TMR2_EXT_OP_N));
   c_ctr1_rise: cover property ($rose(LOCAL_IRQ3));
endmodule
`default_nettype wire

// >>> tiv_host_model.sv
// Host side of the local I/O bus: one-cycle strobes, answer a cycle later.
// Released address and data lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none

module tiv_host_model (
   // Clock
   input wire logic clk,
   // Bus
   output logic [15:0] io_addr,
   output logic io_rd,
   output logic io_wr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_ack
);
   initial begin
      io_addr = 16'h0000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end

   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      begin
         @(posedge clk);
         io_addr <= a;
         io_wdata <= d;
         io_wr <= w;
         io_rd <= !w;
         @(posedge clk);
         io_wr <= 1'b0;
         io_rd <= 1'b0;
         @(posedge clk);
         q = io_rdata;
         ok = io_ack;
         io_addr <= ~a;
         io_wdata <= ~d;
      end
   endtask
endmodule
`default_nettype wire

// >>> tiv_timer_tb_top.sv
// Self-checking bench for the triple interval timer.
// Host model drives the register port; the bench drives counter zero pins.
`timescale 1ns/1ns
`default_nettype none

module tiv_timer_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_pin_n = 1'b1;
   logic gate_pin_n = 1'b1;
   logic modes15_en = 1'b0;
   wire [15:0] io_addr;
   wire [7:0] io_wdata;
   wire [7:0] io_rdata;
   wire io_rd, io_wr, io_ack, op1_n, op2_n, irq, irq3;
   int n_fail = 0;
   int compares = 0;
   int seed;
   logic [15:0] v;
   logic [7:0] q0, q1;

   always #5 clk = ~clk;

   tiv_host_model host (.clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack));
   tiv_timer uut (.CLK_SYS(clk), .RESETN(rst_n), .IO_ADDR(io_addr), .IO_RD(io_rd),
      .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_ACK(io_ack),
      .MODES15_EN(modes15_en), .TMR_MINOR_IP_N(clk_pin_n), .TMR_MAJOR_IP_N(gate_pin_n),
      .TMR1_EXT_OP_N(op1_n), .TMR2_EXT_OP_N(op2_n), .TMR_IRQ(irq), .LOCAL_IRQ3(irq3));

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chkr(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic ok;
      host.acc(1'b1, a, d, q, ok);
      chk8("wr_ack", 8'h01, {7'h00, ok});
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m,
                     output logic [7:0] q);
      logic ok;
      host.acc(1'b0, a, 8'h00, q, ok);
      chk8("rd_ack", 8'h01, {7'h00, ok});
      chk8("rd_data", e & m, q & m);
   endtask

   // Ticks that a loaded value stands for
   function automatic int tk(input logic [15:0] n, input logic bcd);
      tk = bcd ? n[15:12] * 1000 + n[11:8] * 100 + n[7:4] * 10 + n[3:0] : n;
   endfunction

   function automatic logic outv(input logic [1:0] sel);
      outv = (sel == 2'h1) ? irq3 : !op2_n;
   endfunction

   // One-shot on counter 1 or 2, timed in system cycles
   task automatic mode0(input logic [1:0] sel, input logic [1:0] rw, input logic bcd,
                        input logic ctl, input logic [15:0] n);
      int i;
      int t;
      logic [15:0] a;
      t = tk(n, bcd) + 1;
      a = 16'h4000 + {12'h000, sel, 2'h0};
      if (ctl) wr(16'h400C, {sel, rw, 3'h0, bcd});
      wr(a, n[7:0]);
      if (rw == 2'h3) wr(a, n[15:8]);
      chk8("out_low", 8'h00, {7'h00, outv(sel)});
      for (i = 0; i < 10 * t + 30 && outv(sel) !== 1'b1; i++) @(posedge clk);
      chkr("out_rise", 10 * t - 9, 10 * t, i);
   endtask

   // Square wave on counter 1: measure one high and one low phase
   task automatic square1(input logic [15:0] n);
      int i, h, l;
      wr(16'h400C, 8'h76);
      wr(16'h4004, n[7:0]);
      wr(16'h4004, n[15:8]);
      for (i = 0; i < 10 * n + 40 && !(irq3 === 1'b0); i++) @(posedge clk);
      for (i = 0; i < 10 * n + 40 && irq3 !== 1'b1; i++) @(posedge clk);
      for (h = 0; h < 10 * n + 40 && irq3 === 1'b1; h++) @(posedge clk);
      for (l = 0; l < 10 * n + 40 && irq3 === 1'b0; l++) @(posedge clk);
      chkr("sq_high", 5 * (n + 1), 5 * (n + 1), h);
      chkr("sq_low", 5 * (n - 1), 5 * (n - 1), l);
   endtask

   task automatic pin_tick;
      clk_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      clk_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask

   task automatic stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      seed = $urandom(32'h13174344);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      modes15_en <= 1'b1;
      rd(16'h400C, 8'h00, 8'hFF, q0);
      rd(16'h401C, 8'h00, 8'hFF, q0);
      host.acc(1'b1, 16'h3010, 8'h30, q0, q1[0]);
      chk8("ack_outside", 8'h00, {7'h00, q1[0]});
      wr(16'h4010, 8'h30);
      rd(16'h4010, 8'h30, 8'h33, q0);
      mode0(2'h2, 2'h3, 1'b0, 1'b1, 16'd3 + 16'($urandom % 38));
      mode0(2'h2, 2'h3, 1'b1, 1'b1, 16'h0012);
      repeat (3) @(posedge clk);
      chk8("irq_c2", 8'h01, {7'h00, irq});
      rd(16'h4010, 8'h32, 8'h33, q0);
      rd(16'h4014, 8'h32, 8'h33, q0);
      chk8("irq_clr", 8'h00, {7'h00, irq});
      rd(16'h4010, 8'h30, 8'h33, q0);
      v = {8'h01, 8'($urandom)};
      wr(16'h400C, 8'hB0);
      wr(16'h4008, v[7:0]);
      wr(16'h4008, v[15:8]);
      repeat (200) @(posedge clk);
      wr(16'h400C, 8'h80);
      rd(16'h4008, 8'h00, 8'h00, q0);
      rd(16'h4008, 8'h00, 8'h00, q1);
      chkr("latched", v - 22, v - 18, {q1, q0});
      mode0(2'h1, 2'h1, 1'b0, 1'b1, 16'h0004);
      mode0(2'h1, 2'h1, 1'b0, 1'b0, 16'h0002);
      square1(16'h0005);
      square1(16'd7 + 16'(2 * ($urandom % 12)));
      wr(16'h400C, 8'hE4);
      rd(16'h4004, 8'h36, 8'h7F, q0);
      wr(16'h4010, 8'h10);
      wr(16'h400C, 8'h30);
      wr(16'h4000, 8'h03);
      wr(16'h4000, 8'h00);
      repeat (3) pin_tick;
      chk8("irq_early", 8'h00, {7'h00, irq});
      pin_tick;
      chk8("irq_c0", 8'h01, {7'h00, irq});
      rd(16'h4014, 8'h11, 8'h31, q0);
      chk8("irq_c0_clr", 8'h00, {7'h00, irq});
      // Counter zero mode 1: gate fall arms, next tick loads, low N ticks
      wr(16'h400C, 8'h32);
      wr(16'h4000, 8'h02);
      wr(16'h4000, 8'h00);
      gate_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      gate_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      repeat (2) pin_tick;
      chk8("irq_m1_early", 8'h00, {7'h00, irq});
      pin_tick;
      chk8("irq_m1", 8'h01, {7'h00, irq});
      stop_test;
   end
endmodule

bind tiv_timer tiv_timer_props chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .IO_ADDR(IO_ADDR),
   .IO_RD(IO_RD), .IO_WR(IO_WR), .IO_RDATA(IO_RDATA), .IO_ACK(IO_ACK),
   .TMR1_EXT_OP_N(TMR1_EXT_OP_N), .TMR2_EXT_OP_N(TMR2_EXT_OP_N), .TMR_IRQ(TMR_IRQ),
   .LOCAL_IRQ3(LOCAL_IRQ3));
`default_nettype wire
